// >>> verilog/mag_top.sv
// Complex/alpha accumulator and range mask input path with Avalon-MM slave.
// Assumes one clock; flag sources and instruction strobes are synchronous.
`include "mag_cfg.svh"
`default_nettype none
module mag_top (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [6:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic [15:0] ref_x,
    input wire logic line_wptr,
    input wire logic instr_acc_reset,
    input wire logic instr_acc_set,
    input wire logic instr_map_inc,
    input wire mag_pkg::mag_flags_t range_flags,
    input wire mag_pkg::mag_flags_t alu_flags,
    input wire mag_pkg::mag_flags_t depth_flags,
    input wire mag_pkg::mag_flags_t vio_flags,
    output logic [255:0] complex_mask,
    output logic [255:0] range_mask
);
    mag_pkg::mag_state_t s_q;
    mag_pkg::mag_state_t s_d;
    localparam mag_pkg::mag_state_t MAG_RST = '{ctrl: `MAG_CTRL_RESET, waitreq: 1'b1,
        default: '0};

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Pixel i lies at x+i; set from the reference rightwards
    function automatic logic [63:0] edge_mask(input logic [15:0] x, input logic [15:0] r);
        logic [63:0] m;
        m = '0;
        for (int i = 0; i < 64; i++) begin
            m[i] = ({1'b0, x} + 17'(i)) >= {1'b0, r};
        end
        return m;
    endfunction

    function automatic logic [31:0] ctrl_word(input mag_pkg::mag_ctrl_t c);
        return {8'h00, c.range_ptr, c.range_operation, 2'b00, c.input_map,
            c.combine_operation_bit, c.flag_source, 1'b0, c.accumulation_mode,
            1'b0, c.legacy};
    endfunction

    logic take;
    logic wr_ctrl;
    logic wr_start;
    logic wr_end;
    logic wr_comb;
    logic mask_mode;
    logic [63:0] sm;
    logic [63:0] em;
    mag_pkg::mag_flags_t sel;
    logic op4;
    logic op01;
    logic op23;
    logic [3:0] nv;
    logic [3:0] en;
    logic [4:0] ridx;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [3:0] up;
        logic [3:0] dn;
        logic dbit;
        logic old;
        up = '0;
        dn = '0;
        dbit = 1'b0;
        old = 1'b0;
        s_d = s_q;
        take = (read || write) && !s_q.waitreq;
        wr_ctrl = take && write && address == `MAG_ADDR_CTRL;
        wr_start = take && write && address == `MAG_ADDR_START;
        wr_end = take && write && address == `MAG_ADDR_END;
        wr_comb = take && write && address == `MAG_ADDR_COMB;
        ridx = 5'(address[6:2] - 5'h04);

        // One wait state, read data latched on the same edge that drops waitreq
        if ((read || write) && s_q.waitreq) begin
            s_d.waitreq = 1'b0;
            s_d.rdata = '0;
            if (address == `MAG_ADDR_CTRL) begin
                s_d.rdata = ctrl_word(s_q.ctrl);
            end else if (address >= `MAG_ADDR_ACC_BASE && address < `MAG_ADDR_RNG_BASE) begin
                s_d.rdata = s_q.acc[ridx[2:0]*8 +: 8];
            end else if (address >= `MAG_ADDR_RNG_BASE && address < `MAG_ADDR_TOP) begin
                s_d.rdata = s_q.range[ridx[2:1]][ridx[0]*32 +: 32];
            end
        end else begin
            s_d.waitreq = 1'b1;
        end

        // Complex/alpha accumulator
        mask_mode = s_q.ctrl.accumulation_mode[1];
        sm = edge_mask(wr_comb ? writedata[31:16] : writedata[31:16], ref_x);
        em = edge_mask(wr_comb ? writedata[15:0] : writedata[31:16], ref_x);
        for (int i = 0; i < 64; i++) begin
            dbit = !mask_mode && wr_comb && writedata[i % 32]
                && (i / 32 == int'(line_wptr));
            up = {3'b000, mask_mode && (wr_start || wr_comb) && sm[i]}
                + {3'b000, s_q.ctrl.accumulation_mode == mag_pkg::MAG_MASK_INCINC
                    && (wr_end || wr_comb) && em[i]}
                + {3'b000, dbit && s_q.ctrl.accumulation_mode == mag_pkg::MAG_DATA_INC};
            dn = {3'b000, s_q.ctrl.accumulation_mode == mag_pkg::MAG_MASK_INCDEC
                    && (wr_end || wr_comb) && em[i]}
                + {3'b000, dbit && s_q.ctrl.accumulation_mode == mag_pkg::MAG_DATA_DEC};
            s_d.acc[i] = 4'(s_q.acc[i] + up - dn);
        end
        if (instr_acc_reset) begin
            s_d.acc = '0;
        end else if (instr_acc_set) begin
            s_d.acc = {64{`MAG_SET_VALUE}};
        end

        // Range mask input
        unique case (s_q.ctrl.flag_source)
            2'b00: sel = range_flags;
            2'b01: sel = alu_flags;
            2'b10: sel = depth_flags;
            2'b11: sel = vio_flags;
        endcase
        op4 = s_q.ctrl.combine_operation_bit ? |sel.flags : &sel.flags;
        op01 = s_q.ctrl.combine_operation_bit ? |sel.flags[1:0] : &sel.flags[1:0];
        op23 = s_q.ctrl.combine_operation_bit ? |sel.flags[3:2] : &sel.flags[3:2];
        nv = '0;
        en = '0;
        unique case (s_q.ctrl.input_map)
            3'b000: en = 4'h0;
            3'b001: begin
                nv = sel.flags;
                en = 4'hf;
            end
            3'b010: begin
                nv = {2'b00, op23, op01};
                en = 4'h3;
            end
            3'b011: begin
                nv = {op23, op01, 2'b00};
                en = 4'hc;
            end
            default: begin
                nv = {4{op4}};
                en = 4'(4'h1 << s_q.ctrl.input_map[1:0]);
            end
        endcase
        if (sel.valid) begin
            for (int l = 0; l < 4; l++) begin
                old = s_q.range[l][s_q.ctrl.range_ptr];
                if (en[l]) begin
                    unique case (s_q.ctrl.range_operation)
                        mag_pkg::MAG_RNG_NOP: s_d.range[l][s_q.ctrl.range_ptr] = old;
                        mag_pkg::MAG_RNG_AND: s_d.range[l][s_q.ctrl.range_ptr] = old & nv[l];
                        mag_pkg::MAG_RNG_OR: s_d.range[l][s_q.ctrl.range_ptr] = old | nv[l];
                        mag_pkg::MAG_RNG_COPY: s_d.range[l][s_q.ctrl.range_ptr] = nv[l];
                    endcase
                end
            end
            s_d.ctrl.range_ptr = 6'(s_q.ctrl.range_ptr + 6'h01);
        end

        // Map post-increment
        if (instr_map_inc) begin
            if (s_q.ctrl.input_map[2]) begin
                s_d.ctrl.input_map[1:0] = 2'(s_q.ctrl.input_map[1:0] + 2'h1);
            end else if (s_q.ctrl.input_map[1]) begin
                s_d.ctrl.input_map[0] = !s_q.ctrl.input_map[0];
            end
        end

        // Software write overrides hardware steps
        if (wr_ctrl) begin
            s_d.ctrl.range_ptr = writedata[23:18];
            s_d.ctrl.range_operation = mag_pkg::mag_range_operation_t'(writedata[17:16]);
            s_d.ctrl.input_map = writedata[13:11];
            s_d.ctrl.combine_operation_bit = writedata[10];
            s_d.ctrl.flag_source = writedata[9:8];
            s_d.ctrl.accumulation_mode = mag_pkg::mag_acc_mode_t'(writedata[6:5]);
            s_d.ctrl.legacy = writedata[3:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            s_q <= MAG_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign readdata = s_q.rdata;
    assign waitrequest = s_q.waitreq;
    assign complex_mask = s_q.acc;
    assign range_mask = s_q.range;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    logic [5:0] ptr_prev;
    always_ff @(posedge clock) begin
        ptr_prev <= s_q.ctrl.range_ptr;
    end

    sequence arrive_s;
        sel.valid && !wr_ctrl;
    endsequence
    sequence acc_quiet_s;
        !instr_acc_reset && !instr_acc_set;
    endsequence
    sequence copy_one_s;
        arrive_s ##0 (s_q.ctrl.input_map == 3'b001
            && s_q.ctrl.range_operation == mag_pkg::MAG_RNG_COPY);
    endsequence
    sequence and_one_s;
        arrive_s ##0 (s_q.ctrl.input_map == 3'b001
            && s_q.ctrl.range_operation == mag_pkg::MAG_RNG_AND);
    endsequence
    sequence copy_pair_s;
        arrive_s ##0 (s_q.ctrl.input_map == 3'b010
            && s_q.ctrl.range_operation == mag_pkg::MAG_RNG_COPY);
    endsequence
    sequence copy_four_s;
        arrive_s ##0 (s_q.ctrl.input_map[2]
            && s_q.ctrl.range_operation == mag_pkg::MAG_RNG_COPY);
    endsequence
    sequence nop_arrive_s;
        arrive_s ##0 (s_q.ctrl.range_operation == mag_pkg::MAG_RNG_NOP);
    endsequence

    a_bus_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest ##1
        waitrequest) else $error("bus answer not one wait state");
    a_ctrl_reserved: assert property (take && read && address == `MAG_ADDR_CTRL |->
        readdata[31:24] == 8'h00 && readdata[15:14] == 2'b00 && readdata[7] == 1'b0
        && readdata[4] == 1'b0) else $error("reserved bits not zero");

    // ------------------------------------------------------------
    // Range input checks
    // ------------------------------------------------------------
    a_ptr_step: assert property (arrive_s |=> s_q.ctrl.range_ptr ==
        6'($past(s_q.ctrl.range_ptr) + 6'h01)) else $error("range pointer did not step");
    a_ptr_hold: assert property (!sel.valid && !wr_ctrl |=>
        $stable(s_q.ctrl.range_ptr)) else $error("range pointer moved without flags");
    a_range_quiet: assert property (!sel.valid |=> $stable(s_q.range))
        else $error("range mask moved without flags");
    a_copy_insert: assert property (copy_one_s |=>
        s_q.range[0][ptr_prev] == $past(sel.flags[0])
        && s_q.range[3][ptr_prev] == $past(sel.flags[3]))
        else $error("copied flags not stored");
    a_and_insert: assert property (and_one_s |=>
        s_q.range[1][ptr_prev] == ($past(s_q.range[1][s_q.ctrl.range_ptr])
        & $past(sel.flags[1]))) else $error("and with old value wrong");
    a_pair_insert: assert property (copy_pair_s
        ##0 !s_q.ctrl.combine_operation_bit
        |=> s_q.range[0][ptr_prev] == $past(&sel.flags[1:0])
        && s_q.range[1][ptr_prev] == $past(&sel.flags[3:2]))
        else $error("paired flags not stored");
    a_or4_insert: assert property (copy_four_s
        ##0 s_q.ctrl.combine_operation_bit
        |=> s_q.range[$past(s_q.ctrl.input_map[1:0])][ptr_prev] == $past(|sel.flags))
        else $error("or of four flags not stored");
    a_and4_insert: assert property (copy_four_s
        ##0 !s_q.ctrl.combine_operation_bit
        |=> s_q.range[$past(s_q.ctrl.input_map[1:0])][ptr_prev] == $past(&sel.flags))
        else $error("and of four flags not stored");
    a_range_nop: assert property (nop_arrive_s |=> $stable(s_q.range))
        else $error("no-op range operation changed mask");
    a_map_hold_001: assert property (instr_map_inc && !wr_ctrl
        && s_q.ctrl.input_map == 3'b001 |=> s_q.ctrl.input_map == 3'b001)
        else $error("map 001 moved");
    a_map_step_01x: assert property (instr_map_inc && !wr_ctrl
        && s_q.ctrl.input_map == 3'b010 |=> s_q.ctrl.input_map == 3'b011)
        else $error("map 01x step wrong");
    a_map_step_1xx: assert property (instr_map_inc && !wr_ctrl
        && s_q.ctrl.input_map == 3'b111 |=> s_q.ctrl.input_map == 3'b100)
        else $error("map 1xx step wrong");

    // ------------------------------------------------------------
    // Accumulator checks
    // ------------------------------------------------------------
    a_acc_clear: assert property (instr_acc_reset |=> s_q.acc == '0)
        else $error("accumulator not cleared");
    a_acc_set: assert property (instr_acc_set && !instr_acc_reset
        |=> s_q.acc == {64{`MAG_SET_VALUE}}) else $error("accumulator not set");
    a_data_inc: assert property (wr_comb ##0 acc_quiet_s
        ##0 (s_q.ctrl.accumulation_mode == mag_pkg::MAG_DATA_INC
        && !line_wptr && writedata[0])
        |=> s_q.acc[0] == 4'($past(s_q.acc[0]) + 4'h1) && $stable(s_q.acc[32]))
        else $error("data increment wrong");
    a_start_mask: assert property (wr_start ##0 acc_quiet_s
        ##0 (mask_mode && writedata[31:16] >= ref_x)
        |=> s_q.acc[0] == 4'($past(s_q.acc[0]) + 4'h1)) else $error("start mask not added");
    a_end_sub: assert property (wr_end ##0 acc_quiet_s
        ##0 (s_q.ctrl.accumulation_mode == mag_pkg::MAG_MASK_INCDEC
        && writedata[31:16] >= ref_x)
        |=> s_q.acc[0] == 4'($past(s_q.acc[0]) - 4'h1)) else $error("end mask not taken off");
endmodule // mag_top
`default_nettype wire

// >>> verilog/mag_cfg.svh
// Constants of the mask accumulate and range input block.
// Assumes a 32-bit Avalon-MM slave with byte addresses.
`ifndef MAG_CFG_SVH
`define MAG_CFG_SVH
`define MAG_ADDR_CTRL 7'h00
`define MAG_ADDR_START 7'h04
`define MAG_ADDR_END 7'h08
`define MAG_ADDR_COMB 7'h0c
`define MAG_ADDR_ACC_BASE 7'h10
`define MAG_ADDR_RNG_BASE 7'h30
`define MAG_ADDR_TOP 7'h50
`define MAG_CTRL_RESET 20'h00000
`define MAG_SET_VALUE 4'hf
`endif

// >>> verilog/mag_pkg.sv
// Types of the mask accumulate and range input block.
// Assumes nothing beyond the compile order.
`default_nettype none
package mag_pkg;
    typedef enum logic [1:0] {
        MAG_DATA_INC = 2'b00,
        MAG_DATA_DEC = 2'b01,
        MAG_MASK_INCINC = 2'b10,
        MAG_MASK_INCDEC = 2'b11
    } mag_acc_mode_t;
    typedef enum logic [1:0] {
        MAG_RNG_NOP = 2'b00,
        MAG_RNG_AND = 2'b01,
        MAG_RNG_OR = 2'b10,
        MAG_RNG_COPY = 2'b11
    } mag_range_operation_t;
    typedef struct packed {
        logic valid;
        logic [3:0] flags;
    } mag_flags_t;
    // Stored fields of mask_control_two, high to low
    typedef struct packed {
        logic [5:0] range_ptr;
        mag_range_operation_t range_operation;
        logic [2:0] input_map;
        logic combine_operation_bit;
        logic [1:0] flag_source;
        mag_acc_mode_t accumulation_mode;
        logic [3:0] legacy;
    } mag_ctrl_t;
    typedef struct packed {
        mag_ctrl_t ctrl;
        logic [63:0][3:0] acc;
        logic [3:0][63:0] range;
        logic waitreq;
        logic [31:0] rdata;
    } mag_state_t;
endpackage
`default_nettype wire

// >>> test/mag_flag_src.sv
// Far-side model of the range, ALU, depth and vector IO flag units.
// Assumes the bench raises go for one cycle per arrival, off the sampling edge.
`default_nettype none
module mag_flag_src (
    input wire logic clock,
    input wire logic go,
    input wire logic [1:0] sel,
    input wire logic [3:0] flags,
    output var mag_pkg::mag_flags_t [3:0] src
);
    logic [3:0] junk = 4'h5;
    always @(posedge clock) begin
        junk <= ~junk;
        for (int s = 0; s < 4; s++) begin
            // Every unit reports on go; only the chosen one carries real flags
            src[s].valid <= go;
            src[s].flags <= (go && s == sel) ? flags : junk;
        end
    end
endmodule // mag_flag_src
`default_nettype wire

// >>> test/mag_top_bench.sv
// Self-checking bench of the mask accumulate and range input block.
// Assumes mag_pkg, mag_top and mag_flag_src are compiled first.
`include "mag_cfg.svh"
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
$display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module mag_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, rstn = 0, read = 0, write = 0, line_wptr = 0, go = 0;
    logic instr_acc_reset = 0, instr_acc_set = 0, instr_map_inc = 0, waitrequest;
    logic [6:0] address = 0;
    logic [31:0] writedata = 0, readdata, rd, d;
    logic [15:0] ref_x = 0;
    logic [3:0] flags = 0;
    logic [255:0] complex_mask, range_mask;
    logic [511:0] em = 0;
    mag_pkg::mag_flags_t [3:0] src;
    int miscompares = 0, num_checks = 0, op, k;
    int acc[64] = '{default: 0};
    bit [63:0] rng[4];
    bit [31:0] ctl = 0;
    mag_top dut_u (.clock(clock), .rstn(rstn), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .ref_x(ref_x),
        .line_wptr(line_wptr), .instr_acc_reset(instr_acc_reset),
        .instr_acc_set(instr_acc_set), .instr_map_inc(instr_map_inc), .range_flags(src[0]),
        .alu_flags(src[1]), .depth_flags(src[2]), .vio_flags(src[3]),
        .complex_mask(complex_mask), .range_mask(range_mask));
    mag_flag_src far_u (.clock(clock), .go(go), .sel(ctl[9:8]), .flags(flags), .src(src));
    // ------------------------------------------------------------
    // Bus, model and comparison tasks
    // ------------------------------------------------------------
    function automatic bit [63:0] gm(bit [15:0] x);
        for (int i = 0; i < 64; i++) gm[i] = ({1'b0, x} + 17'(i)) >= {1'b0, ref_x};
    endfunction
    task automatic bus(bit wr, bit [6:0] a, bit [31:0] wd, output logic [31:0] q);
        @(posedge clock);
        address <= a;
        writedata <= wd;
        read <= !wr;
        write <= wr;
        do begin
            @(posedge clock);
        end while (waitrequest !== 1'b0);
        q = readdata;
        read <= 0;
        write <= 0;
    endtask
    task automatic check;
        repeat (2) @(posedge clock);
        for (int i = 0; i < 64; i++) em[4*i+:4] = acc[i][3:0];
        for (int l = 0; l < 4; l++) em[256+64*l+:64] = rng[l];
        `CHK(complex_mask, em[255:0])
        `CHK(range_mask, em[511:256])
    endtask
    task automatic entry(bit [6:0] a);
        bit [63:0] s, e;
        bit [31:0] w;
        w = {ref_x + 16'($urandom % 140) - 16'd70, 16'($urandom)};
        if (a == `MAG_ADDR_COMB) w = {w[31:16], w[31:16] + 16'($urandom % 80)};
        if (a == `MAG_ADDR_COMB && $urandom % 2) w = $urandom;
        bus(1, a, w, rd);
        s = a == `MAG_ADDR_END ? 64'h0 : gm(w[31:16]);
        e = a == `MAG_ADDR_START ? 64'h0 : gm(a == `MAG_ADDR_END ? w[31:16] : w[15:0]);
        for (int i = 0; i < 64; i++)
            if (ctl[6]) acc[i] = (acc[i] + s[i] + (ctl[5] ? -e[i] : e[i])) & 15;
            else if (a == `MAG_ADDR_COMB && i / 32 == line_wptr)
                acc[i] = (acc[i] + (ctl[5] ? -w[i % 32] : w[i % 32])) & 15;
        check;
    endtask
    task automatic arrive;
        bit [3:0] f, n, w;
        bit a01, a23, a4;
        int p;
        f = 4'($urandom);
        @(posedge clock);
        go <= 1;
        flags <= f;
        @(posedge clock);
        go <= 0;
        p = ctl[23:18];
        a01 = ctl[10] ? |f[1:0] : &f[1:0];
        a23 = ctl[10] ? |f[3:2] : &f[3:2];
        a4 = ctl[10] ? |f : &f;
        w = ctl[13:11] == 3'd0 ? 4'h0 : 4'hf;
        n = f;
        if (ctl[13:12] == 2'b01) begin
            w = ctl[11] ? 4'hc : 4'h3;
            n = {2{a23, a01}};
        end
        if (ctl[13]) begin
            w = 4'h1 << ctl[12:11];
            n = {4{a4}};
        end
        for (int l = 0; l < 4; l++)
            if (w[l] && ctl[17:16] != 2'd0)
                rng[l][p] = ctl[17] ? (ctl[16] ? n[l] : rng[l][p] | n[l]) : rng[l][p] & n[l];
        ctl[23:18] = p + 1;
        check;
    endtask
    task automatic instr;
        bit [2:0] r;
        r = 3'($urandom);
        @(posedge clock);
        {instr_acc_reset, instr_acc_set, instr_map_inc} <= r;
        @(posedge clock);
        {instr_acc_reset, instr_acc_set, instr_map_inc} <= 3'h0;
        for (int i = 0; i < 64; i++) if (r[2] || r[1]) acc[i] = r[2] ? 0 : 15;
        if (r[0] && ctl[13]) ctl[12:11] = ctl[12:11] + 2'd1;
        else if (r[0] && ctl[12]) ctl[11] = !ctl[11];
        bus(0, `MAG_ADDR_CTRL, 0, rd);
        `CHK(rd, ctl)
        check;
    endtask
    task give_verdict;
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        forever #2 clock = ~clock;
    end
    initial begin
        #200000;
        miscompares++;
        give_verdict;
    end
    initial begin
        repeat (4) @(posedge clock);
        rstn <= 1;
        void'($urandom(124));
        bus(0, `MAG_ADDR_CTRL, 0, rd);
        `CHK(rd, 32'h0)
        check;
        for (int it = 0; it < 700; it++) begin
            op = $urandom % 7;
            if (op == 0) begin
                d = $urandom;
                ref_x <= 16'($urandom);
                line_wptr <= 1'($urandom);
                bus(1, `MAG_ADDR_CTRL, d, rd);
                ctl = d & 32'h00ff3f6f;
                bus(0, `MAG_ADDR_CTRL, 0, rd);
                `CHK(rd, ctl)
            end
            if (op == 1) entry(`MAG_ADDR_START);
            if (op == 2) entry(`MAG_ADDR_END);
            if (op == 3) entry(`MAG_ADDR_COMB);
            if (op == 4) arrive();
            if (op == 5) instr();
            if (op == 6) begin
                k = $urandom % 20;
                if (k % 2) bus(1, `MAG_ADDR_ACC_BASE + 7'(4 * k), $urandom, rd);
                bus(0, `MAG_ADDR_ACC_BASE + 7'(4 * k), 0, rd);
                `CHK(rd, k < 16 ? em[32*k+:32] : 32'h0)
                check;
            end
        end
        give_verdict;
    end
endmodule // mag_top_bench
`default_nettype wire
